// ===== serial_link_top.sv
// How it works
// - Two serial ports, each with its own independent configuration set.
// - Each port runs either standard Modbus or the custom packet link.
// - Each port flags a frame starting with its own slave address in standard mode; resets to 247 and 246.
// - Bit rates 1200 up to 460800 selectable per port.
// - No reply within the timeout after sending declares a timeout; default 3000 ms.
// - Configured delay between a reply and the next request; default 0 ms.
// - Failed transaction retried up to 0..255 times, then communication stops.
// - Custom link frames are built from stored packet bytes, not a fixed protocol.
// - Triggered group runs its commands in order with their repeat counts.
// - Triggered sequence runs several groups in configured order.
// - Per-port option enables recording of that port's traffic history.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module serial_link_top
  import serial_link_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [9:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic             irq_out,
  output logic [1:0]       txd_out,
  output logic [1:0]       drv_en_out,
  input  wire logic [1:0]  rxd_in
);
  generate
    if (MS_CYCLES < 1 || MS_CYCLES > 262144) begin : g_bad_ms
      $error("MS_CYCLES out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire        glob_sel = reg_addr_in[9];
  wire        port_sel = reg_addr_in[8];
  wire [7:0]  ofs      = reg_addr_in[7:0];
  wire [2:0]  word_idx = ofs[4:2];
  wire        wr_port  = reg_wr_in && !glob_sel;
  wire        wr_cfg   = wr_port && ofs == OFS_CFG;
  wire        wr_time  = wr_port && ofs == OFS_TIME;
  wire        wr_retry = wr_port && ofs == OFS_RETRY;
  wire        wr_ctrl  = wr_port && ofs == OFS_CTRL;
  wire        wr_seq   = wr_port && ofs == OFS_SEQ;
  wire        wr_cmd   = wr_port && ofs[7:5] == REGION_CMD;
  wire        wr_pkt   = wr_port && ofs[7:5] == REGION_PKT;
  wire        wr_ist   = reg_wr_in && glob_sel && ofs == OFS_INT_ST;
  wire        wr_imk   = reg_wr_in && glob_sel && ofs == OFS_INT_MK;

  port_cfg_t  cfg_q   [N_PORTS];
  logic [15:0] tmo_q  [N_PORTS];
  logic [15:0] dly_q  [N_PORTS];
  logic [7:0]  retry_q[N_PORTS];
  logic [13:0] seq_q  [N_PORTS];
  cmd_t        cmd_q  [N_PORTS][N_CMDS];
  logic [7:0]  pkt_q  [N_PORTS][N_PKT_BYTES];
  logic [7:0]  ist_q;
  logic [7:0]  imk_q;
  logic [31:0] rdata_q;
  logic [7:0]  ev_w;
  logic [1:0]  busy_w;
  logic [1:0]  fail_w;
  logic [7:0]  last_rx_w [N_PORTS];
  logic [15:0] hist_w    [N_PORTS];
  logic        ms_tick;
  logic [17:0] ms_cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration storage, one set per port
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int p = 0; p < N_PORTS; p++) begin
        cfg_q[p]   <= '{slave: (p == 0) ? SLAVE_RST0 : SLAVE_RST1,
                        baud: BAUD_RST, default: 1'b0};
        tmo_q[p]   <= TIMEOUT_RST;
        dly_q[p]   <= DELAY_RST;
        retry_q[p] <= RETRY_RST;
        seq_q[p]   <= 14'h0;
        for (int c = 0; c < N_CMDS; c++) cmd_q[p][c] <= '0;
        for (int b = 0; b < N_PKT_BYTES; b++) pkt_q[p][b] <= 8'h00;
      end
    end else begin
      if (wr_cfg)   cfg_q[port_sel]   <= port_cfg_t'(reg_wdata_in[15:0]);
      if (wr_time) begin
        tmo_q[port_sel] <= reg_wdata_in[15:0];
        dly_q[port_sel] <= reg_wdata_in[31:16];
      end
      if (wr_retry) retry_q[port_sel] <= reg_wdata_in[7:0];
      if (wr_seq)   seq_q[port_sel]   <= reg_wdata_in[13:0];
      if (wr_cmd)   cmd_q[port_sel][word_idx] <= cmd_t'(reg_wdata_in[16:0]);
      if (wr_pkt) begin
        for (int k = 0; k < 4; k++) begin
          pkt_q[port_sel][{word_idx, 2'(k)}] <= reg_wdata_in[8*k +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond enable shared by both ports
  assign ms_tick = (ms_cnt_q == 18'(MS_CYCLES - 1));

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) ms_cnt_q <= 18'h0;
    else           ms_cnt_q <= ms_tick ? 18'h0 : ms_cnt_q + 18'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port engine
  genvar g;
  generate
    for (g = 0; g < N_PORTS; g++) begin : g_port
      seq_state_t  st_q;
      port_cfg_t   act_q;
      logic [15:0] act_tmo_q;
      logic [15:0] act_dly_q;
      logic [7:0]  act_retry_q;
      logic [2:0]  cmd_i_q;
      logic [3:0]  byte_i_q;
      logic [2:0]  rx_n_q;
      logic [7:0]  rep_q;
      logic [7:0]  try_q;
      logic [15:0] ms_q;
      logic        seq_mode_q;
      logic [1:0]  seq_pos_q;
      logic        fail_q;
      logic        gap_q;
      logic [7:0]  last_q;
      logic [15:0] hist_q;
      logic        tx_ready;
      logic        rx_valid;
      logic [7:0]  rx_data;

      wire cmd_t  cur      = cmd_q[g][cmd_i_q];
      wire        prefix   = act_q.ascii && !act_q.custom;
      wire [3:0]  tx_total = {1'b0, cur.tx_len_m1} + 4'h1 + {3'h0, prefix};
      wire [2:0]  pb_idx   = 3'(byte_i_q - {3'h0, prefix});
      wire [7:0]  tx_byte  = (prefix && byte_i_q == 4'h0) ? ASCII_START
                           : pkt_q[g][{cur.pkt, pb_idx}];
      wire        tx_go    = st_q == S_SEND && tx_ready;
      wire        got_all  = (cur.rx_len == 3'h0 && tx_ready)
                           || (rx_valid && rx_n_q + 3'h1 == cur.rx_len);
      wire        in_wait  = st_q == S_WAIT;
      wire        waited   = in_wait && tx_ready && ms_tick
                           && ms_q + 16'h1 >= act_tmo_q;
      wire        success  = in_wait && got_all;
      wire        tmo_ev   = waited && !success;
      wire        give_up  = tmo_ev && try_q == 8'h0;
      wire        more_grp = seq_mode_q && seq_pos_q != seq_q[g][SEQ_CNT_POS +: 2];
      wire [1:0]  nxt_pos  = seq_pos_q + 2'h1;
      wire [2:0]  nxt_cmd  = cur.last ? seq_q[g][3*nxt_pos +: 3] : cmd_i_q + 3'h1;
      wire        trig     = wr_ctrl && port_sel == 1'(g);
      wire        trig_grp = trig && reg_wdata_in[CTRL_GROUP_BIT];
      wire        trig_seq = trig && reg_wdata_in[CTRL_SEQ_BIT];
      wire [2:0]  start_i  = trig_seq ? seq_q[g][2:0]
                           : reg_wdata_in[CTRL_START_POS +: 3];
      wire        done_ev  = success && rep_q == 8'h0 && cur.last && !more_grp;
      wire        addr_ev  = rx_valid && gap_q && !cfg_q[g].custom
                           && rx_data == cfg_q[g].slave;

      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          st_q        <= S_IDLE;
          act_q       <= '0;
          act_tmo_q   <= TIMEOUT_RST;
          act_dly_q   <= DELAY_RST;
          act_retry_q <= RETRY_RST;
          cmd_i_q     <= 3'h0;
          byte_i_q    <= 4'h0;
          rx_n_q      <= 3'h0;
          rep_q       <= 8'h0;
          try_q       <= 8'h0;
          ms_q        <= 16'h0;
          seq_mode_q  <= 1'b0;
          seq_pos_q   <= 2'h0;
          fail_q      <= 1'b0;
        end else begin
          case (st_q)
            S_IDLE: begin
              if (trig_grp || trig_seq) begin
                act_q       <= cfg_q[g];
                act_tmo_q   <= tmo_q[g];
                act_dly_q   <= dly_q[g];
                act_retry_q <= retry_q[g];
                try_q       <= retry_q[g];
                seq_mode_q  <= trig_seq;
                seq_pos_q   <= 2'h0;
                cmd_i_q     <= start_i;
                rep_q       <= cmd_q[g][start_i].repeat_n;
                fail_q      <= 1'b0;
                byte_i_q    <= 4'h0;
                st_q        <= S_SEND;
              end
            end
            S_DELAY: begin
              if (ms_q >= act_dly_q) begin
                st_q     <= S_SEND;
                byte_i_q <= 4'h0;
              end else if (ms_tick) begin
                ms_q <= ms_q + 16'h1;
              end
            end
            S_SEND: begin
              if (tx_go) begin
                byte_i_q <= byte_i_q + 4'h1;
                if (byte_i_q + 4'h1 == tx_total) begin
                  st_q   <= S_WAIT;
                  ms_q   <= 16'h0;
                  rx_n_q <= 3'h0;
                end
              end
            end
            S_WAIT: begin
              if (rx_valid) rx_n_q <= rx_n_q + 3'h1;
              if (tx_ready && ms_tick) ms_q <= ms_q + 16'h1;
              if (success) begin
                ms_q  <= 16'h0;
                st_q  <= S_DELAY;
                try_q <= act_retry_q;
                if (rep_q != 8'h0) begin
                  rep_q <= rep_q - 8'h1;
                end else if (cur.last && !more_grp) begin
                  st_q <= S_IDLE;
                end else begin
                  if (cur.last) seq_pos_q <= nxt_pos;
                  cmd_i_q <= nxt_cmd;
                  rep_q   <= cmd_q[g][nxt_cmd].repeat_n;
                end
              end else if (tmo_ev) begin
                ms_q <= 16'h0;
                if (give_up) begin
                  st_q   <= S_IDLE;
                  fail_q <= 1'b1;
                end else begin
                  try_q <= try_q - 8'h1;
                  st_q  <= S_DELAY;
                end
              end
            end
            default: st_q <= S_IDLE;
          endcase
        end
      end

      // A millisecond tick with no byte since marks the next byte as a frame start
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          gap_q  <= 1'b1;
          last_q <= 8'h00;
          hist_q <= 16'h0;
        end else begin
          if (rx_valid)     gap_q <= 1'b0;
          else if (ms_tick) gap_q <= 1'b1;
          if (rx_valid)     last_q <= rx_data;
          if (cfg_q[g].hist_en && (tx_go || rx_valid)) begin
            hist_q <= hist_q + 16'h1;
          end
        end
      end

      uart_byte_engine u_uart (
        .clk_in       (core_clk_in),
        .rst_n_in     (rst_n_in),
        .div_in       (baud_div(act_q.baud)),
        .tx_valid_in  (tx_go),
        .tx_data_in   (tx_byte),
        .tx_ready_out (tx_ready),
        .txd_out      (txd_out[g]),
        .rxd_in       (rxd_in[g]),
        .rx_valid_out (rx_valid),
        .rx_data_out  (rx_data)
      );

      // Half-duplex RS-485 drives only while a byte is out; RS-422 always drives
      assign drv_en_out[g]  = act_q.phys422 || !tx_ready;
      assign busy_w[g]      = st_q != S_IDLE;
      assign fail_w[g]      = fail_q;
      assign last_rx_w[g]   = last_q;
      assign hist_w[g]      = hist_q;
      assign ev_w[4*g +: 4] = {tmo_ev, addr_ev, give_up, done_ev};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event wins over a same-cycle clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ist_q <= 8'h00;
      imk_q <= 8'h00;
    end else begin
      ist_q <= (ist_q & ~(wr_ist ? reg_wdata_in[7:0] : 8'h00)) | ev_w;
      if (wr_imk) imk_q <= reg_wdata_in[7:0];
    end
  end

  assign irq_out = |(ist_q & imk_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  wire cmd_t   rd_cmd  = cmd_q[port_sel][word_idx];
  wire [31:0]  rd_pkt  = {pkt_q[port_sel][{word_idx, 2'h3}], pkt_q[port_sel][{word_idx, 2'h2}],
                          pkt_q[port_sel][{word_idx, 2'h1}], pkt_q[port_sel][{word_idx, 2'h0}]};
  wire [31:0]  rd_stat = {hist_w[port_sel], last_rx_w[port_sel], 6'h0,
                          fail_w[port_sel], busy_w[port_sel]};
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    if (glob_sel) begin
      if (ofs == OFS_INT_ST) rd_mux = {24'h0, ist_q};
      if (ofs == OFS_INT_MK) rd_mux = {24'h0, imk_q};
    end else if (ofs[7:5] == REGION_CMD) begin
      rd_mux = {15'h0, rd_cmd};
    end else if (ofs[7:5] == REGION_PKT) begin
      rd_mux = rd_pkt;
    end else begin
      case (ofs)
        OFS_CFG:   rd_mux = {16'h0, cfg_q[port_sel]};
        OFS_TIME:  rd_mux = {dly_q[port_sel], tmo_q[port_sel]};
        OFS_RETRY: rd_mux = {24'h0, retry_q[port_sel]};
        OFS_CTRL:  rd_mux = {31'h0, busy_w[port_sel]};
        OFS_SEQ:   rd_mux = {18'h0, seq_q[port_sel]};
        OFS_STAT:  rd_mux = rd_stat;
        default:   rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rdata_q <= 32'h0;
    else           rdata_q <= reg_rd_in ? rd_mux : 32'h0;
  end

  assign reg_rdata_out = rdata_q;

endmodule

// ===== serial_link_pkg.sv
package serial_link_pkg;

  localparam int CLK_HZ        = 250_000_000;
  localparam int MS_TIME_MS    = 1;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * MS_TIME_MS;
  localparam int N_PORTS       = 2;
  localparam int N_CMDS        = 8;
  localparam int N_PKT_BYTES   = 32;

  // Register byte offsets inside a port block (addr[8] = port) and the global block (addr[9] = 1)
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_TIME   = 8'h04;
  localparam logic [7:0] OFS_RETRY  = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_SEQ    = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;
  localparam logic [2:0] REGION_CMD = 3'h2;
  localparam logic [2:0] REGION_PKT = 3'h4;
  localparam logic [7:0] OFS_INT_ST = 8'h00;
  localparam logic [7:0] OFS_INT_MK = 8'h04;

  // Control and sequence register fields
  localparam int CTRL_GROUP_BIT = 0;
  localparam int CTRL_SEQ_BIT   = 1;
  localparam int CTRL_START_POS = 2;
  localparam int SEQ_CNT_POS    = 12;

  // Event bits, four per port
  localparam int EV_DONE = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_ADDR = 2;
  localparam int EV_TMO  = 3;

  localparam logic [7:0]  SLAVE_RST0   = 8'hf7;    // 247
  localparam logic [7:0]  SLAVE_RST1   = 8'hf6;    // 246
  localparam logic [3:0]  BAUD_RST     = 4'h3;     // 9600
  localparam logic [15:0] TIMEOUT_RST  = 16'h0bb8; // 3000 ms
  localparam logic [15:0] DELAY_RST    = 16'h0000; // 0 ms
  localparam logic [7:0]  RETRY_RST    = 8'h03;
  localparam logic [7:0]  ASCII_START  = 8'h3a;

  typedef struct packed {
    logic [7:0] slave;
    logic [3:0] baud;
    logic       hist_en;
    logic       ascii;
    logic       phys422;
    logic       custom;
  } port_cfg_t;

  typedef struct packed {
    logic       last;
    logic [7:0] repeat_n;
    logic [2:0] rx_len;
    logic [2:0] tx_len_m1;
    logic [1:0] pkt;
  } cmd_t;

  typedef enum logic [1:0] {S_IDLE, S_DELAY, S_SEND, S_WAIT} seq_state_t;

  function automatic logic [17:0] baud_div(input logic [3:0] sel);
    case (sel)
      4'h0:    baud_div = 18'(CLK_HZ / 1200);
      4'h1:    baud_div = 18'(CLK_HZ / 2400);
      4'h2:    baud_div = 18'(CLK_HZ / 4800);
      4'h4:    baud_div = 18'(CLK_HZ / 19200);
      4'h5:    baud_div = 18'(CLK_HZ / 38400);
      4'h6:    baud_div = 18'(CLK_HZ / 57600);
      4'h7:    baud_div = 18'(CLK_HZ / 76800);
      4'h8:    baud_div = 18'(CLK_HZ / 115200);
      4'h9:    baud_div = 18'(CLK_HZ / 230400);
      4'ha:    baud_div = 18'(CLK_HZ / 460800);
      default: baud_div = 18'(CLK_HZ / 9600);
    endcase
  endfunction

endpackage

// ===== uart_byte_engine.sv
`timescale 1ns/1ps
module uart_byte_engine
  import serial_link_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [17:0] div_in,
  input  wire logic        tx_valid_in,
  input  wire logic [7:0]  tx_data_in,
  output logic             tx_ready_out,
  output logic             txd_out,
  input  wire logic        rxd_in,
  output logic             rx_valid_out,
  output logic [7:0]       rx_data_out
);
  logic [17:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  logic [17:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_valid_q;
  logic [7:0]  rx_data_q;

  assign tx_ready_out = (tx_bit_q == 4'h0);
  assign txd_out      = tx_sh_q[0];
  assign rx_valid_out = rx_valid_q;
  assign rx_data_out  = rx_data_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit, 8N1
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_cnt_q <= 18'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 10'h3ff;
    end else if (tx_bit_q == 4'h0) begin
      if (tx_valid_in) begin
        tx_sh_q  <= {1'b1, tx_data_in, 1'b0};
        tx_bit_q <= 4'ha;
        tx_cnt_q <= div_in - 18'h1;
      end
    end else if (tx_cnt_q == 18'h0) begin
      tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
      tx_bit_q <= tx_bit_q - 4'h1;
      tx_cnt_q <= div_in - 18'h1;
    end else begin
      tx_cnt_q <= tx_cnt_q - 18'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive, sampled mid-bit; a false start bit is dropped
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_cnt_q   <= 18'h0;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_data_q  <= 8'h00;
    end else begin
      rx_valid_q <= 1'b0;
      if (rx_bit_q == 4'h0) begin
        if (!rxd_in) begin
          rx_bit_q <= 4'ha;
          rx_cnt_q <= div_in >> 1;
        end
      end else if (rx_cnt_q != 18'h0) begin
        rx_cnt_q <= rx_cnt_q - 18'h1;
      end else begin
        rx_cnt_q <= div_in - 18'h1;
        rx_bit_q <= (rx_bit_q == 4'ha && rxd_in) ? 4'h0 : rx_bit_q - 4'h1;
        if (rx_bit_q == 4'h1) begin
          rx_valid_q <= rxd_in;
          rx_data_q  <= rx_sh_q;
        end else if (rx_bit_q != 4'ha) begin
          rx_sh_q <= {rxd_in, rx_sh_q[7:1]};
        end
      end
    end
  end

endmodule

// ===== serial_link_properties.sv
`timescale 1ns/1ps
module serial_link_properties (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic [9:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        irq_out,
  input wire logic [1:0]  txd_out,
  input wire logic [1:0]  drv_en_out,
  input wire logic [1:0]  rxd_in
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  // Write, one quiet cycle, read back
  sequence wr_rd(logic [9:0] a);
    reg_wr_in && reg_addr_in == a ##1 !reg_wr_in ##1 reg_rd_in && reg_addr_in == a;
  endsequence
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero");
  a_hole_zero: assert property (reg_rd_in && reg_addr_in == 10'h2fc |=> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_back: assert property (wr_rd(10'h000) |=>
    ((reg_rdata_out ^ $past(reg_wdata_in, 3)) & 32'h0000ffff) == 32'h0)
    else $error("config readback wrong");
  a_retry_back: assert property (wr_rd(10'h008) |=>
    ((reg_rdata_out ^ $past(reg_wdata_in, 3)) & 32'h000000ff) == 32'h0)
    else $error("retry readback wrong");
  a_mask_off: assert property (reg_wr_in && reg_addr_in == 10'h204 &&
    reg_wdata_in == 32'h0 |=> !irq_out)
    else $error("irq high with mask clear");
  a_drive_tx0: assert property (!txd_out[0] |-> drv_en_out[0])
    else $error("port 0 low without driver");
  a_drive_tx1: assert property (!txd_out[1] |-> drv_en_out[1])
    else $error("port 1 low without driver");
  a_start_len0: assert property ($fell(txd_out[0]) |-> !txd_out[0] [*8])
    else $error("port 0 start bit short");
  a_start_len1: assert property ($fell(txd_out[1]) |-> !txd_out[1] [*8])
    else $error("port 1 start bit short");
  c_irq: cover property ($rose(irq_out));
  c_tx1: cover property ($fell(txd_out[1]));
  c_rx0: cover property ($fell(rxd_in[0]));
endmodule

bind serial_link_top serial_link_properties serial_link_properties_i (
  .core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .irq_out, .txd_out, .drv_en_out, .rxd_in
);

// ===== serial_far_end.sv
`timescale 1ns/1ps
module serial_far_end #(
  parameter int BIT_CYC = 542
)(
  input  wire logic clk_in,
  input  wire logic txd_in,
  output logic      rxd_out
);
  logic [7:0] got[$];
  logic [7:0] b;
  ////////////////////////////////////////
  // Mid-bit sampling; stop bit not judged
  initial begin
    rxd_out = 1'b1;
    forever begin
      @(negedge txd_in);
      repeat (BIT_CYC / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_in);
        b[i] = txd_in;
      end
      repeat (BIT_CYC) @(posedge clk_in);
      got.push_back(b);
    end
  end
  ////////////////////////////////////////
  // Line biased high when released
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (BIT_CYC) @(posedge clk_in);
    end
  endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import serial_link_pkg::*;
  localparam int MS  = 50;
  localparam int BIT = CLK_HZ / 460800;
  logic        core_clk_in;
  logic        rst_n_in;
  logic [9:0]  reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  wire  [31:0] reg_rdata_out;
  wire         irq_out;
  wire  [1:0]  txd_out;
  wire  [1:0]  drv_en_out;
  wire  [1:0]  rxd_in;
  int          n_mismatch;
  int          comparisons;

  serial_link_top #(.MS_CYCLES(MS)) serial_link_top_i (
    .core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .irq_out, .txd_out, .drv_en_out, .rxd_in
  );
  serial_far_end #(.BIT_CYC(BIT)) fe0 (
    .clk_in(core_clk_in), .txd_in(txd_out[0]), .rxd_out(rxd_in[0]));
  serial_far_end #(.BIT_CYC(BIT)) fe1 (
    .clk_in(core_clk_in), .txd_in(txd_out[1]), .rxd_out(rxd_in[1]));
  ////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobe dropped with a spare edge, so back-to-back calls never clash
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rc(input string nm, input logic [9:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] g;
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 g = reg_rdata_out;
    chk(nm, e, g & m);
    @(posedge core_clk_in);
  endtask
  // Realigns to a rising edge so the next drive stays on the edge
  task automatic irq_chk(input logic e);
    #1 chk("irq", {31'h0, e}, {31'h0, irq_out});
    @(posedge core_clk_in);
  endtask
  task automatic wait_idle(input logic p);
    logic [31:0] g;
    for (int i = 0; i < 500; i++) begin
      reg_addr_in <= {1'b0, p, 8'h14};
      reg_rd_in   <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 g = reg_rdata_out;
      @(posedge core_clk_in);
      if (g[0] === 1'b0) return;
      repeat (99) @(posedge core_clk_in);
    end
    n_mismatch++;
    close_out();
  endtask
  task automatic bchk(input logic p, input int n, input logic [31:0] e);
    logic [7:0] q[$];
    q = p ? fe1.got : fe0.got;
    chk("count", n, q.size());
    for (int i = 0; i < n; i++) chk("byte", {24'h0, e[8*i +: 8]}, {24'h0, q[i]});
    fe0.got.delete();
    fe1.got.delete();
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    n_mismatch   = 0;
    comparisons  = 0;
    rst_n_in     = 1'b0;
    reg_wr_in    = 1'b0;
    reg_rd_in    = 1'b0;
    reg_addr_in  = 10'h000;
    reg_wdata_in = 32'h0;
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    rc("cfg0", 10'h000, 32'h0000f730, '1);
    rc("cfg1", 10'h100, 32'h0000f630, '1);
    rc("time0", 10'h004, 32'h00000bb8, '1);
    rc("retry0", 10'h008, 32'h00000003, '1);
    rc("hole", 10'h2fc, 32'h0, '1);
    irq_chk(1'b0);
    for (int k = 0; k < 11; k++) begin
      wr(10'h100, {16'h0, 8'hf6, 4'(k), 4'h0});
      rc("baud1", 10'h100, {16'h0, 8'hf6, 4'(k), 4'h0}, '1);
    end
    wr(10'h000, 32'h0000f7a9);
    rc("cfg0", 10'h000, 32'h0000f7a9, '1);
    rc("cfg1", 10'h100, 32'h0000f6a0, '1);
    // Two-command group; repeated trigger while busy must be ignored
    // Timeout covers a whole reply byte at the top rate
    wr(10'h004, 32'h000000c8);
    wr(10'h080, 32'h0000a355);
    wr(10'h088, 32'h000000c3);
    wr(10'h040, 32'h00000004);
    wr(10'h044, 32'h00010021);
    wr(10'h00c, 32'h00000001);
    wr(10'h00c, 32'h00000001);
    rc("busy", 10'h00c, 32'h1, '1);
    chk("drv_en", 32'h1, {30'h0, drv_en_out});
    for (int i = 0; i < 30000 && fe0.got.size() < 3; i++) @(posedge core_clk_in);
    if (fe0.got.size() < 3) begin
      n_mismatch++;
      close_out();
    end
    fe0.send(8'h5a);
    wait_idle(1'b0);
    chk("drv_en", 32'h0, {30'h0, drv_en_out});
    bchk(1'b0, 3, 32'h00c3a355);
    rc("stat0", 10'h014, 32'h00045a00, '1);
    rc("int", 10'h200, 32'h00000001, '1);
    irq_chk(1'b0);
    wr(10'h204, 32'h00000001);
    irq_chk(1'b1);
    wr(10'h200, 32'h00000001);
    irq_chk(1'b0);
    wr(10'h204, 32'h00000000);
    // Silent far end: one retry after a 2 ms gap, then abort
    wr(10'h004, 32'h00020001);
    rc("time0", 10'h004, 32'h00020001, '1);
    wr(10'h008, 32'h00000001);
    rc("retry0", 10'h008, 32'h00000001, '1);
    wr(10'h00c, 32'h00000005);
    wait_idle(1'b0);
    bchk(1'b0, 2, 32'h0000c3c3);
    rc("stat0", 10'h014, 32'h00000002, 32'h00000003);
    rc("int", 10'h200, 32'h0000000a, '1);
    wr(10'h200, 32'h000000ff);
    // Sequence of two groups, slot 0 first
    wr(10'h044, 32'h00010001);
    wr(10'h048, 32'h00010000);
    wr(10'h010, 32'h0000100a);
    wr(10'h00c, 32'h00000002);
    wait_idle(1'b0);
    bchk(1'b0, 2, 32'h0000c355);
    rc("int", 10'h200, 32'h00000001, '1);
    wr(10'h200, 32'h000000ff);
    // Second port, standard protocol with character framing
    wr(10'h100, 32'h0000f6a6);
    wr(10'h180, 32'h00000011);
    wr(10'h140, 32'h00010000);
    wr(10'h10c, 32'h00000001);
    wait_idle(1'b1);
    chk("drv_en", 32'h2, {30'h0, drv_en_out});
    bchk(1'b1, 2, 32'h0000113a);
    fe1.send(8'hf6);
    repeat (BIT) @(posedge core_clk_in);
    rc("int", 10'h200, 32'h00000050, '1);
    rc("hist1", 10'h114, 32'h0, 32'hffff0000);
    close_out();
  end
endmodule
